// File: vmsc_pkg.sv
// Package with register layout, encodings and reset values for the block.
package vmsc_pkg;

	// System register encodings (op1, CRn, CRm, op2 concatenated).
	localparam logic [13:0] SYSREG_STATUS_ENC  = 14'h32da;
	localparam logic [13:0] SYSREG_CONTROL_ENC = 14'h32df;

	// Maintenance status bit positions.
	localparam int unsigned ST_GRP1_DIS = 7;
	localparam int unsigned ST_GRP1_EN  = 6;
	localparam int unsigned ST_GRP0_DIS = 5;
	localparam int unsigned ST_GRP0_EN  = 4;
	localparam int unsigned ST_NO_PEND  = 3;
	localparam int unsigned ST_NOT_PRES = 2;
	localparam int unsigned ST_UNDERFL  = 1;
	localparam int unsigned ST_EOI      = 0;
	localparam int unsigned ST_WIDTH    = 8;

	// Control register field positions.
	localparam int unsigned CT_PMASK_LSB  = 24;
	localparam int unsigned CT_BP0_LSB    = 21;
	localparam int unsigned CT_BP1_LSB    = 18;
	localparam int unsigned CT_SPLIT_EOI  = 9;
	localparam int unsigned CT_COMMON_BP  = 4;
	localparam int unsigned CT_FIQ_SEL    = 3;
	localparam int unsigned CT_ACK_CTL    = 2;
	localparam int unsigned CT_GRP1_EN    = 1;
	localparam int unsigned CT_GRP0_EN    = 0;

	// Reset values, binary point ceiling and spurious identity.
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	localparam logic [7:0]  STATUS_RESET  = 8'h00;
	localparam logic [2:0]  BP_SATURATE   = 3'h7;
	localparam logic [9:0]  SPURIOUS_ID   = 10'h3fe;

	// Access levels of the requester.
	typedef enum logic [1:0] {
		VMSC_LVL_OTHER,
		VMSC_LVL_HYP,
		VMSC_LVL_MON
	} vmsc_level_t;

	// List register state field codes.
	localparam logic [1:0] LR_INACTIVE = 2'h0;
	localparam logic [1:0] LR_PENDING  = 2'h1;
	localparam logic [1:0] LR_ACTIVE   = 2'h2;
	localparam logic [1:0] LR_PEND_ACT = 2'h3;

endpackage : vmsc_pkg

// File: vmsc_lr_scan.sv
// Counts valid list register entries and detects any pending one for maintenance flags.
module vmsc_lr_scan import vmsc_pkg::*; #(
	parameter int unsigned NUM_LR = 16
) (
	input  wire logic [2*NUM_LR-1:0] lr_state,
	output logic                     none_pending,
	output logic                     at_most_one
);

	// Inactive entries count neither as valid nor as pending, though the scan sees every state field.
	// Direct-set packets never reach this scan, only list state does.
	always_comb begin
		int unsigned valid_cnt;
		logic        pend_any;
		valid_cnt = 0;
		pend_any  = 1'b0;
		for (int i = 0; i < NUM_LR; i++) begin
			if (lr_state[2*i +: 2] != LR_INACTIVE) begin
				valid_cnt = valid_cnt + 1;
			end
			if (lr_state[2*i +: 2] == LR_PENDING ||
			    lr_state[2*i +: 2] == LR_PEND_ACT) begin
				pend_any = 1'b1;
			end
		end
		none_pending = !pend_any;
		at_most_one  = (valid_cnt <= 1);
	end

endmodule : vmsc_lr_scan

// File: vmsc_bpoint.sv
// Binary point handling: write clamp and common-point read-back.
module vmsc_bpoint import vmsc_pkg::*; (
	input  wire logic [2:0] bp0_wdata,
	input  wire logic [2:0] bp0_cur,
	input  wire logic [2:0] min_bp0,
	output logic      [2:0] bp0_clamped,
	output logic      [2:0] bp1_view
);

	// Values below the minimum are raised to it rather than refused.
	always_comb begin
		bp0_clamped = (bp0_wdata < min_bp0) ? min_bp0 : bp0_wdata;
		bp1_view    = (bp0_cur == BP_SATURATE) ? BP_SATURATE :
		              bp0_cur + 3'h1;
	end

endmodule : vmsc_bpoint

// File: vmsc_top.sv
// Virtual interface maintenance status and virtual machine control block.
module vmsc_top import vmsc_pkg::*; #(
	parameter int unsigned NUM_LR   = 16,
	parameter int unsigned PRE_BITS = 5,
	parameter int unsigned EOIC_W   = 5,
	parameter bit          SRE_FIXED = 1'b0,
	parameter bit          HYP_IMPL  = 1'b1
) (
	input  wire logic                clock,
	input  wire logic                srst,
	input  wire logic                clk_en,
	input  wire logic                reg_valid,
	input  wire logic                reg_write,
	input  wire logic [13:0]         reg_enc,
	input  wire logic [31:0]         reg_wdata,
	input  wire vmsc_level_t         reg_level,
	input  wire logic                sysreg_access_enable_hyp,
	input  wire logic                sysreg_access_enable_mon,
	input  wire logic                bp1_write,
	input  wire logic [2:0]          bp1_wdata,
	input  wire logic                bp0_write,
	input  wire logic [2:0]          bp0_wdata,
	input  wire logic                grp1_disabled_irq_en,
	input  wire logic                grp1_enabled_irq_en,
	input  wire logic                grp0_disabled_irq_en,
	input  wire logic                grp0_enabled_irq_en,
	input  wire logic                no_pending_irq_en,
	input  wire logic                entry_not_present_irq_en,
	input  wire logic                underflow_irq_en,
	input  wire logic [EOIC_W-1:0]   end_of_irq_counter,
	input  wire logic [NUM_LR-1:0]   end_of_irq_status,
	input  wire logic [2*NUM_LR-1:0] lr_state,
	input  wire logic                hp_valid,
	input  wire logic [7:0]          hp_priority,
	input  wire logic                hp_group1,
	input  wire logic [9:0]          hp_id,
	input  wire logic                eoi_write,
	input  wire logic                dir_write,
	output logic [31:0]              reg_rdata,
	output logic                     reg_done,
	output logic                     reg_trap,
	output logic                     maint_irq,
	output logic                     virq_out,
	output logic                     vfiq_out,
	output logic [9:0]               ack_id,
	output logic [2:0]               bp1_rdata,
	output logic [2:0]               bp0_rdata,
	output logic                     prio_drop,
	output logic                     deactivate
);

	////////////////////////////////////////////////////////////////////////
	// Control register fields and outputs held in flip-flops.

	logic [7:0]  pmask_q, pmask_d;
	logic [2:0]  bp0_q, bp0_d, bp1_q, bp1_d;
	logic        split_q, split_d, cbp_q, cbp_d, fiq_q, fiq_d;
	logic        ack_q, ack_d, en1_q, en1_d, en0_q, en0_d;
	logic [ST_WIDTH-1:0] status_q, status_d;
	logic [31:0] rdata_q, rdata_d;
	logic        done_q, done_d, trap_q, trap_d, mirq_q, mirq_d;
	logic        virq_q, virq_d, vfiq_q, vfiq_d;
	logic [9:0]  ack_id_q, ack_id_d;
	logic [2:0]  bp0r_q, bp1r_q, bp1_view, bp0_clamp, bpw_clamp;
	logic        drop_q, drop_d, deact_q, deact_d;
	logic        none_pending, at_most_one;
	logic [2:0]  min_bp0;

	// The minimum group-zero point follows the implemented preemption bits.
	assign min_bp0 = 3'(7 - PRE_BITS);

	vmsc_lr_scan #(
		.NUM_LR       (NUM_LR)
	) u_scan (
		.lr_state     (lr_state),
		.none_pending (none_pending),
		.at_most_one  (at_most_one)
	);

	// One instance clamps bus writes, the other the direct point register.
	vmsc_bpoint u_bp_bus (
		.bp0_wdata   (reg_wdata[CT_BP0_LSB +: 3]),
		.bp0_cur     (bp0_q),
		.min_bp0     (min_bp0),
		.bp0_clamped (bp0_clamp),
		.bp1_view    (bp1_view)
	);

	vmsc_bpoint u_bp_dir (
		.bp0_wdata   (bp0_wdata),
		.bp0_cur     (bp0_q),
		.min_bp0     (min_bp0),
		.bp0_clamped (bpw_clamp),
		.bp1_view    ()
	);

	////////////////////////////////////////////////////////////////////////
	// Register access: decode, trap check and control updates.

	// A trapped access changes nothing; it only answers with the trap pulse.
	// Unknown encodings and an absent hypervisor level both read as zero.
	always_comb begin
		logic hit_st, hit_ct, trapped, live;
		logic [31:0] ctl_word;
		hit_st   = (reg_enc == SYSREG_STATUS_ENC);
		hit_ct   = (reg_enc == SYSREG_CONTROL_ENC);
		trapped  = (reg_level == VMSC_LVL_HYP && !sysreg_access_enable_hyp) ||
		           (reg_level == VMSC_LVL_MON && !sysreg_access_enable_mon);
		live     = reg_valid && !trapped && HYP_IMPL;
		ctl_word = {pmask_q, bp0_q, bp1_q, 8'h00, split_q, 4'h0, cbp_q,
		            fiq_q, ack_q, en1_q, en0_q};
		pmask_d  = pmask_q;
		bp0_d    = bp0_q;
		bp1_d    = bp1_q;
		split_d  = split_q;
		cbp_d    = cbp_q;
		fiq_d    = fiq_q;
		ack_d    = ack_q;
		en1_d    = en1_q;
		en0_d    = en0_q;
		rdata_d  = rdata_q;
		done_d   = reg_valid && !trapped;
		trap_d   = reg_valid && trapped;
		if (reg_valid && !trapped) begin
			rdata_d = 32'h0000_0000;
		end
		if (live && !reg_write) begin
			if (hit_st) begin
				rdata_d = {24'h00_0000, status_q};
			end else if (hit_ct) begin
				rdata_d = ctl_word;
			end
		end
		if (live && reg_write && hit_ct) begin
			pmask_d = reg_wdata[CT_PMASK_LSB +: 8];
			bp0_d   = bp0_clamp;
			bp1_d   = reg_wdata[CT_BP1_LSB +: 3];
			split_d = reg_wdata[CT_SPLIT_EOI];
			cbp_d   = reg_wdata[CT_COMMON_BP];
			fiq_d   = reg_wdata[CT_FIQ_SEL];
			ack_d   = reg_wdata[CT_ACK_CTL];
			en1_d   = reg_wdata[CT_GRP1_EN];
			en0_d   = reg_wdata[CT_GRP0_EN];
		end
		// Guest-side binary point writes; group one is frozen in common mode.
		if (bp0_write) begin
			bp0_d = bpw_clamp;
		end
		if (bp1_write && !cbp_d) begin
			bp1_d = bp1_wdata;
		end
		if (SRE_FIXED) begin
			ack_d = 1'b0;
			fiq_d = 1'b1;
		end
	end

	// Control fields and bus answer registers; clock enable low holds all.
	// The group-zero point resets to its minimum so control reads never show it illegal.
	always_ff @(posedge clock) begin
		if (srst) begin
			pmask_q <= CONTROL_RESET[CT_PMASK_LSB +: 8];
			bp0_q   <= min_bp0;
			bp1_q   <= CONTROL_RESET[CT_BP1_LSB +: 3];
			split_q <= CONTROL_RESET[CT_SPLIT_EOI];
			cbp_q   <= CONTROL_RESET[CT_COMMON_BP];
			fiq_q   <= SRE_FIXED;
			ack_q   <= CONTROL_RESET[CT_ACK_CTL];
			en1_q   <= CONTROL_RESET[CT_GRP1_EN];
			en0_q   <= CONTROL_RESET[CT_GRP0_EN];
			rdata_q <= 32'h0000_0000;
			done_q  <= 1'b0;
			trap_q  <= 1'b0;
		end else if (clk_en) begin
			pmask_q <= pmask_d;
			bp0_q   <= bp0_d;
			bp1_q   <= bp1_d;
			split_q <= split_d;
			cbp_q   <= cbp_d;
			fiq_q   <= fiq_d;
			ack_q   <= ack_d;
			en1_q   <= en1_d;
			en0_q   <= en0_d;
			rdata_q <= rdata_d;
			done_q  <= done_d;
			trap_q  <= trap_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Maintenance status: a level view of the current conditions.

	always_comb begin
		status_d = STATUS_RESET;
		status_d[ST_GRP1_DIS] = grp1_disabled_irq_en && !en1_q;
		status_d[ST_GRP1_EN]  = grp1_enabled_irq_en && en1_q;
		status_d[ST_GRP0_DIS] = grp0_disabled_irq_en && !en0_q;
		status_d[ST_GRP0_EN]  = grp0_enabled_irq_en && en0_q;
		status_d[ST_NO_PEND]  = no_pending_irq_en && none_pending;
		status_d[ST_NOT_PRES] = entry_not_present_irq_en &&
		                        (end_of_irq_counter != '0);
		status_d[ST_UNDERFL]  = underflow_irq_en && at_most_one;
		status_d[ST_EOI]      = |end_of_irq_status;
		// Without a hypervisor level nothing may raise a maintenance flag.
		if (!HYP_IMPL) begin
			status_d = STATUS_RESET;
		end
		// The request is formed from next flags so it lines up with status.
		mirq_d = |status_d;
	end

	// Status is registered so the request output comes from a flip-flop.
	// The price is one cycle of lag behind the hypervisor enables.
	always_ff @(posedge clock) begin
		if (srst) begin
			status_q <= STATUS_RESET;
			mirq_q   <= 1'b0;
		end else if (clk_en) begin
			status_q <= status_d;
			mirq_q   <= mirq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Virtual interrupt signalling, acknowledge identity and completion.

	always_comb begin
		logic fire, enabled;
		// Lower numeric priority is more urgent, so it must sit below the mask.
		enabled  = hp_group1 ? en1_q : en0_q;
		fire     = hp_valid && enabled && (hp_priority < pmask_q);
		virq_d   = fire && (hp_group1 || !fiq_q);
		vfiq_d   = fire && !hp_group1 && fiq_q;
		// Legacy readers see the spurious identity for a hidden group one.
		ack_id_d = (hp_valid && hp_group1 && !ack_q) ? SPURIOUS_ID : hp_id;
		// With split mode off a deactivate write has no defined effect; drop it.
		drop_d   = eoi_write;
		deact_d  = split_q ? dir_write : eoi_write;
	end

	// Signalling outputs and guest-view binary points, one cycle behind.
	// In common mode the group-one view is derived, never stored.
	always_ff @(posedge clock) begin
		if (srst) begin
			virq_q   <= 1'b0;
			vfiq_q   <= 1'b0;
			ack_id_q <= 10'h000;
			drop_q   <= 1'b0;
			deact_q  <= 1'b0;
			bp0r_q   <= 3'h0;
			bp1r_q   <= 3'h0;
		end else if (clk_en) begin
			virq_q   <= virq_d;
			vfiq_q   <= vfiq_d;
			ack_id_q <= ack_id_d;
			drop_q   <= drop_d;
			deact_q  <= deact_d;
			bp0r_q   <= bp0_d;
			bp1r_q   <= cbp_d ? bp1_view : bp1_d;
		end
	end

	// Every output is a plain copy of a flip-flop, with no gating after it.
	// That keeps downstream timing independent of the decode logic.
	assign reg_rdata  = rdata_q;
	assign reg_done   = done_q;
	assign reg_trap   = trap_q;
	assign maint_irq  = mirq_q;
	assign virq_out   = virq_q;
	assign vfiq_out   = vfiq_q;
	assign ack_id     = ack_id_q;
	assign bp0_rdata  = bp0r_q;
	assign bp1_rdata  = bp1r_q;
	assign prio_drop  = drop_q;
	assign deactivate = deact_q;

endmodule : vmsc_top

// File: vmsc_props.sv
// Checker for answer timing, traps and output causes of the block.
module vmsc_props import vmsc_pkg::*; #(
	parameter int unsigned NUM_LR = 16
) (
	input wire logic		clock,
	input wire logic		srst,
	input wire logic		clk_en,
	input wire logic		reg_valid,
	input wire vmsc_level_t		reg_level,
	input wire logic		sysreg_access_enable_hyp,
	input wire logic		sysreg_access_enable_mon,
	input wire logic [NUM_LR-1:0]	end_of_irq_status,
	input wire logic		hp_valid,
	input wire logic		eoi_write,
	input wire logic		dir_write,
	input wire logic		reg_done,
	input wire logic		reg_trap,
	input wire logic		maint_irq,
	input wire logic		virq_out,
	input wire logic		prio_drop,
	input wire logic		deactivate
);
	// All checks share the core clock and its synchronous reset.
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	// A taken access gets exactly one answer, one cycle later.
	chk_one_answer: assert property (
		reg_valid && clk_en |=> reg_done != reg_trap)
		else $error("access not answered once");
	chk_hyp_trap: assert property (
		reg_valid && clk_en && reg_level == VMSC_LVL_HYP &&
		!sysreg_access_enable_hyp |=> reg_trap)
		else $error("hypervisor access not trapped");
	chk_mon_trap: assert property (
		reg_valid && clk_en && reg_level == VMSC_LVL_MON &&
		!sysreg_access_enable_mon |=> reg_trap)
		else $error("monitor access not trapped");
	chk_hyp_done: assert property (
		reg_valid && clk_en && reg_level == VMSC_LVL_HYP &&
		sysreg_access_enable_hyp |=> reg_done)
		else $error("enabled access not completed");

	// Output events must follow their causes by one cycle.
	chk_eoi_maint: assert property (
		clk_en && end_of_irq_status != '0 |=> maint_irq)
		else $error("end status did not raise request");
	chk_eoi_drop: assert property (
		eoi_write && clk_en |=> prio_drop)
		else $error("end write gave no priority drop");
	chk_deact_cause: assert property (
		deactivate |-> $past(eoi_write) || $past(dir_write))
		else $error("deactivate without a cause");
	chk_virq_cause: assert property (
		virq_out |-> $past(hp_valid))
		else $error("virtual irq without a candidate");
endmodule // vmsc_props

////////////////////////////////////////////////////////////////////////////
bind vmsc_top vmsc_props #(.NUM_LR(NUM_LR)) chk_u (
	.clock, .srst, .clk_en, .reg_valid, .reg_level,
	.sysreg_access_enable_hyp, .sysreg_access_enable_mon,
	.end_of_irq_status, .hp_valid, .eoi_write, .dir_write, .reg_done,
	.reg_trap, .maint_irq, .virq_out, .prio_drop, .deactivate
);

// File: vmsc_cpu_model.sv
// Processor model that issues system register accesses to the block.
module vmsc_cpu_model import vmsc_pkg::*; (
	input wire logic	clock,
	input wire logic	reg_trap,
	input wire logic [31:0]	reg_rdata,
	output logic		reg_valid,
	output logic		reg_write,
	output logic [13:0]	reg_enc,
	output logic [31:0]	reg_wdata,
	output vmsc_level_t	reg_level
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle request lines at time zero.
	initial begin
		{reg_valid, reg_write, reg_enc, reg_wdata} = '0;
		reg_level = VMSC_LVL_HYP;
	end

	// One-cycle request; the answer is sampled one edge after it is taken.
	task automatic access(input logic w, input logic [13:0] e,
		input logic [31:0] d, input vmsc_level_t l,
		output logic [31:0] rd, output logic tr);
		@(posedge clock);
		reg_valid <= 1'b1;
		reg_write <= w;
		reg_enc <= e;
		reg_wdata <= d;
		reg_level <= l;
		@(posedge clock);
		reg_valid <= 1'b0;
		reg_wdata <= ~d; // Stale data must not look valid.
		@(posedge clock);
		rd = reg_rdata;
		tr = reg_trap;
	endtask
endmodule // vmsc_cpu_model

// File: vmsc_top_tb.sv
// Self-checking bench for the maintenance status and control block.
module vmsc_top_tb import vmsc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic		clock = 0, srst = 1, clk_en = 1, hp_valid = 0;
	logic		bp1_write = 0, bp0_write = 0, hp_group1 = 0;
	logic		eoi_write = 0, dir_write = 0, tr, sre_h = 1, sre_m = 1;
	logic [2:0]	bp1_wdata = 0, bp0_wdata = 0, bp1_rdata, bp0_rdata;
	logic [6:0]	hen = 0;
	logic [4:0]	eoic = 0;
	logic [15:0]	eis = 0;
	logic [31:0]	lrs = 0, rd, reg_wdata, reg_rdata, f_rdata;
	logic [7:0]	hp_priority = 0;
	logic [9:0]	hp_id = 0, ack_id;
	logic [13:0]	reg_enc;
	logic		reg_valid, reg_write, reg_done, reg_trap, maint_irq;
	logic		virq_out, vfiq_out, prio_drop, deactivate;
	vmsc_level_t	reg_level;
	int		fail_count = 0, n_checks = 0, cyc = 0;

	// Design and the processor model facing its register port.
	vmsc_top dut_u (.clock, .srst, .clk_en, .reg_valid, .reg_write,
		.reg_enc, .reg_wdata, .reg_level,
		.sysreg_access_enable_hyp(sre_h), .sysreg_access_enable_mon(sre_m),
		.bp1_write, .bp1_wdata, .bp0_write, .bp0_wdata,
		.grp1_disabled_irq_en(hen[6]), .grp1_enabled_irq_en(hen[5]),
		.grp0_disabled_irq_en(hen[4]), .grp0_enabled_irq_en(hen[3]),
		.no_pending_irq_en(hen[2]), .entry_not_present_irq_en(hen[1]),
		.underflow_irq_en(hen[0]), .end_of_irq_counter(eoic),
		.end_of_irq_status(eis), .lr_state(lrs), .hp_valid, .hp_priority,
		.hp_group1, .hp_id, .eoi_write, .dir_write, .reg_rdata, .reg_done,
		.reg_trap, .maint_irq, .virq_out, .vfiq_out, .ack_id, .bp1_rdata,
		.bp0_rdata, .prio_drop, .deactivate);
	vmsc_cpu_model cpu_u (.clock, .reg_trap, .reg_rdata, .reg_valid,
		.reg_write, .reg_enc, .reg_wdata, .reg_level);
	// Second copy with the register enable fixed, for its hardwired bits.
	vmsc_top #(.SRE_FIXED(1'b1)) dut_f (.clock, .srst, .clk_en,
		.reg_valid, .reg_write, .reg_enc, .reg_wdata, .reg_level,
		.sysreg_access_enable_hyp(sre_h), .sysreg_access_enable_mon(sre_m),
		.bp1_write, .bp1_wdata, .bp0_write, .bp0_wdata,
		.grp1_disabled_irq_en(hen[6]), .grp1_enabled_irq_en(hen[5]),
		.grp0_disabled_irq_en(hen[4]), .grp0_enabled_irq_en(hen[3]),
		.no_pending_irq_en(hen[2]), .entry_not_present_irq_en(hen[1]),
		.underflow_irq_en(hen[0]), .end_of_irq_counter(eoic),
		.end_of_irq_status(eis), .lr_state(lrs), .hp_valid,
		.hp_priority, .hp_group1, .hp_id, .eoi_write, .dir_write,
		.reg_rdata(f_rdata), .reg_done(), .reg_trap(), .maint_irq(),
		.virq_out(), .vfiq_out(), .ack_id(), .bp1_rdata(),
		.bp0_rdata(), .prio_drop(), .deactivate());

	// Clock and a cycle ceiling that cuts a hang short.
	always #10 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			results;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Shared helpers.
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic wr(input logic [31:0] d);
		cpu_u.access(1'b1, SYSREG_CONTROL_ENC, d, VMSC_LVL_HYP, rd, tr);
	endtask
	task automatic rdr(input logic [13:0] e);
		cpu_u.access(1'b0, e, 32'h0, VMSC_LVL_HYP, rd, tr);
	endtask
	// Flags follow their levels by a cycle, so wait two edges.
	task automatic st(input logic [6:0] h, input logic [4:0] c,
		input logic [15:0] s, input logic [31:0] l, input logic [7:0] e);
		hen <= h;
		eoic <= c;
		eis <= s;
		lrs <= l;
		tick(2);
		chk({31'h0, maint_irq}, {31'h0, |e});
		rdr(SYSREG_STATUS_ENC);
		chk(rd, {24'h0, e});
	endtask
	task automatic vo(input logic [1:0] iv, input logic [9:0] id);
		tick(2);
		chk({30'h0, virq_out, vfiq_out}, {30'h0, iv});
		if (iv != 2'b00) chk({22'h0, ack_id}, {22'h0, id});
	endtask
	task automatic pl(input logic e, input logic d, input logic [1:0] x);
		@(posedge clock);
		eoi_write <= e;
		dir_write <= d;
		@(posedge clock);
		eoi_write <= 1'b0;
		dir_write <= 1'b0;
		@(posedge clock);
		chk({30'h0, prio_drop, deactivate}, {30'h0, x});
	endtask

	////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_reset;
		rdr(SYSREG_STATUS_ENC);
		chk(rd, 32'h0);
		rdr(SYSREG_CONTROL_ENC);
		chk(rd, 32'h0040_0000);
		chk(f_rdata, 32'h0040_0008);
		rdr(14'h0000);
		chk(rd, 32'h0);
	endtask
	task automatic t_status;
		st(7'h40, 0, 0, 0, 8'h80);
		st(7'h20, 0, 0, 0, 8'h00);
		st(7'h10, 0, 0, 0, 8'h20);
		st(7'h04, 0, 0, 0, 8'h08);
		st(7'h05, 0, 0, 32'h0000_0005, 8'h00);
		st(7'h05, 0, 0, 32'h0000_000a, 8'h08);
		st(7'h05, 0, 0, 32'h4000_0000, 8'h02);
		st(7'h02, 5'h10, 0, 0, 8'h04);
		st(7'h02, 0, 0, 0, 8'h00);
		st(7'h00, 0, 16'h8000, 0, 8'h01);
		wr(32'h0000_0003);
		st(7'h60, 0, 0, 0, 8'h40);
		st(7'h18, 0, 0, 0, 8'h10);
		st(7'h00, 0, 0, 0, 8'h00);
	endtask
	// A guest group-one write must be dropped while the point is common.
	task automatic t_ctrl;
		wr(32'hffff_ffff);
		rdr(SYSREG_CONTROL_ENC);
		chk(rd, 32'hfffc_021f);
		chk(f_rdata, 32'hfffc_021b);
		chk({29'h0, bp1_rdata}, 32'h7);
		wr(32'h0020_0010);
		@(posedge clock);
		bp1_write <= 1'b1;
		bp1_wdata <= 3'h5;
		@(posedge clock);
		bp1_write <= 1'b0;
		tick(2);
		chk({26'h0, bp1_rdata, bp0_rdata}, 32'h1a);
		wr(32'h0000_0000);
		// Guest group-zero writes: a legal value sticks, a low one clamps.
		@(posedge clock);
		bp0_write <= 1'b1;
		bp0_wdata <= 3'h5;
		@(posedge clock);
		bp0_wdata <= 3'h1;
		@(posedge clock);
		chk({29'h0, bp0_rdata}, 32'h5);
		bp0_write <= 1'b0;
		@(posedge clock);
		chk({29'h0, bp0_rdata}, 32'h2);
		@(posedge clock);
		bp1_write <= 1'b1;
		@(posedge clock);
		bp1_write <= 1'b0;
		tick(2);
		rdr(SYSREG_CONTROL_ENC);
		chk(rd, 32'h0054_0000);
	endtask
	task automatic t_trap;
		for (int i = 0; i < 2; i++) begin
			{sre_h, sre_m} <= i ? 2'b10 : 2'b01;
			cpu_u.access(1'b1, SYSREG_CONTROL_ENC, 32'h3,
				i ? VMSC_LVL_MON : VMSC_LVL_HYP, rd, tr);
			chk({31'h0, tr}, 32'h1);
		end
		{sre_h, sre_m} <= 2'b11;
		rdr(SYSREG_CONTROL_ENC);
		chk(rd, 32'h0054_0000);
	endtask
	task automatic t_virq;
		wr(32'h8000_000f);
		{hp_valid, hp_group1, hp_priority, hp_id} <= {2'b11, 8'h40, 10'h2a};
		vo(2'b10, 10'h2a);
		hp_group1 <= 1'b0;
		vo(2'b01, 10'h2a);
		hp_priority <= 8'h80;
		vo(2'b00, 10'h0);
		wr(32'h8000_0003);
		{hp_group1, hp_priority} <= {1'b1, 8'h40};
		vo(2'b10, SPURIOUS_ID);
		hp_group1 <= 1'b0;
		vo(2'b10, 10'h2a);
		wr(32'h8000_0002);
		vo(2'b00, 10'h0);
		hp_group1 <= 1'b1;
		vo(2'b10, SPURIOUS_ID);
		hp_valid <= 1'b0;
	endtask
	task automatic t_eoi;
		pl(1'b1, 1'b0, 2'b11);
		pl(1'b0, 1'b1, 2'b00);
		wr(32'h0000_0203);
		pl(1'b1, 1'b0, 2'b10);
		pl(1'b0, 1'b1, 2'b01);
	endtask
	// Clock enable low must hold all state; then a reset in mid-run.
	task automatic t_freeze;
		clk_en <= 1'b0;
		hen <= 7'h20;
		tick(3);
		chk({31'h0, maint_irq}, 32'h0);
		clk_en <= 1'b1;
		tick(2);
		chk({31'h0, maint_irq}, 32'h1);
		srst <= 1'b1;
		tick(2);
		srst <= 1'b0;
		rdr(SYSREG_STATUS_ENC);
		chk(rd, 32'h0);
		rdr(SYSREG_CONTROL_ENC);
		chk(rd, 32'h0040_0000);
	endtask

	// Report counts and verdict, then stop.
	task automatic results;
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Main sequence: five reset cycles, then every scenario.
	initial begin
		tick(5);
		srst <= 1'b0;
		t_reset;
		t_status;
		t_ctrl;
		t_trap;
		t_virq;
		t_eoi;
		t_freeze;
		results;
	end
endmodule // vmsc_top_tb
